// *** dv/dam_host.sv ***
// Purpose: serial front end model issuing byte accesses
// Assumes: one request pulse, answer read one cycle later
// Notes:   released lines show inverted values so stale data never matches
`timescale 1ns/1ps
module dam_host (
    input  wire logic       core_clk,
    input  wire logic       acc_ack,
    input  wire logic       acc_wr_done,
    input  wire logic       acc_wr_refused,
    input  wire logic [7:0] acc_rdata,
    output logic            acc_req,
    output logic            acc_wr,
    output logic [7:0]      acc_dev,
    output logic [7:0]      acc_off,
    output logic [7:0]      acc_wdata
);
    initial begin
        {acc_req, acc_wr, acc_dev, acc_off, acc_wdata} = '0;
    end
    task automatic xfer(input logic [7:0] d, input logic w, input logic [7:0] o, v,
                        output logic ak, dn, rf, output logic [7:0] rd);
        @(posedge core_clk);
        acc_req   <= 1'b1;
        acc_wr    <= w;
        acc_dev   <= d;
        acc_off   <= o;
        acc_wdata <= v;
        @(posedge core_clk);
        acc_req   <= 1'b0;
        acc_dev   <= ~d;
        acc_off   <= ~o;
        acc_wdata <= ~v;
        @(negedge core_clk);
        ak = acc_ack;
        dn = acc_wr_done;
        rf = acc_wr_refused;
        rd = acc_rdata;
    endtask : xfer
endmodule : dam_host

// *** dv/dam_monitor.sv ***
// Purpose: port checker for dam_top
// Assumes: the main device address is never set to A0h
// Notes:   bound to every dam_top instance below
`timescale 1ns/1ps
module dam_monitor
    import dam_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       acc_req,
    input wire logic [7:0] acc_dev,
    input wire logic       acc_wr,
    input wire logic [7:0] acc_off,
    input logic            acc_ack,
    input logic            acc_wr_done,
    input logic            acc_wr_refused,
    input logic [7:0]      acc_rdata,
    input wire logic       monitor_alarm_summary,
    input logic            buffer_a_output,
    input logic            buffer_a_output_oen,
    input logic            buffer_b_output
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // offsets compared against DEV_AUX only, since the main address may move
    sequence s_meas_wr;
        acc_req && acc_wr && acc_dev != DEV_AUX && acc_off inside {[8'h60:8'h69]};
    endsequence
    sequence s_sram_wr;
        acc_req && acc_wr && acc_dev != DEV_AUX && acc_off inside {[8'h6A:8'h7F]};
    endsequence
    a_ack_cause: assert property (acc_ack |-> $past(acc_req))
        else $error("ack without a request");
    a_write_resp: assert property (acc_ack && $past(acc_wr) |-> acc_wr_done != acc_wr_refused)
        else $error("acked write without exactly one outcome");
    a_resp_acked: assert property (acc_wr_done || acc_wr_refused |-> acc_ack && $past(acc_wr))
        else $error("write outcome without acked write");
    a_meas_readonly: assert property (s_meas_wr |=> !acc_wr_done)
        else $error("result byte accepted a write");
    a_sram_open: assert property (s_sram_wr ##1 acc_ack |-> acc_wr_done)
        else $error("sram write not accepted");
    a_rdata_idle: assert property (!$past(acc_req) |-> acc_rdata == 8'h00)
        else $error("read data not cleared when idle");
    a_alarm_wins: assert property ($past(monitor_alarm_summary) |-> buffer_a_output_oen)
        else $error("alarm did not assert buffer a");
    a_drain_low: assert property (!buffer_a_output && !buffer_b_output)
        else $error("open drain data not low");
endmodule : dam_monitor

bind dam_top dam_monitor u_mon (
    .core_clk(core_clk), .rstn(rstn), .acc_req(acc_req), .acc_dev(acc_dev),
    .acc_wr(acc_wr), .acc_off(acc_off), .acc_ack(acc_ack), .acc_wr_done(acc_wr_done),
    .acc_wr_refused(acc_wr_refused), .acc_rdata(acc_rdata),
    .monitor_alarm_summary(monitor_alarm_summary), .buffer_a_output(buffer_a_output),
    .buffer_a_output_oen(buffer_a_output_oen), .buffer_b_output(buffer_b_output)
);

// *** dv/tb_top.sv ***
// Purpose: directed test of dam_top through its byte access port
// Assumes: lookup tables written before temperature mode is checked
// Notes:   expected values built from the register map, not the design
`timescale 1ns/1ps
module tb_top;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [15:0] temp_word = 16'h1900;
    logic        wp = 1'b0, alarm = 1'b0, in_a = 1'b0, in_b = 1'b0;
    logic        acc_req, acc_wr, acc_ack, acc_wr_done, acc_wr_refused;
    logic [7:0]  acc_dev, acc_off, acc_wdata, acc_rdata, res0, res1, rb;
    logic        oa, ob, oea, oeb, a, dn, rf;
    int          n_fail = 0, n_compared = 0;
    wire  [79:0] res_all = {temp_word, 16'hC350, 16'h1234, 16'hABCD, 16'h00FF};
    always #5 core_clk = ~core_clk;
    dam_top uut (
        .core_clk(core_clk), .rstn(rstn), .acc_req(acc_req), .acc_dev(acc_dev),
        .acc_wr(acc_wr), .acc_off(acc_off), .acc_wdata(acc_wdata), .acc_ack(acc_ack),
        .acc_wr_done(acc_wr_done), .acc_wr_refused(acc_wr_refused), .acc_rdata(acc_rdata),
        .temp_word(temp_word), .vcc_word(res_all[63:48]), .mon1_word(res_all[47:32]),
        .mon2_word(res_all[31:16]), .mon3_word(res_all[15:0]), .write_protect_pin(wp),
        .monitor_alarm_summary(alarm), .buffer_a_input(in_a), .buffer_b_input(in_b),
        .buffer_a_output(oa), .buffer_a_output_oen(oea), .buffer_b_output(ob),
        .buffer_b_output_oen(oeb), .res0_position(res0), .res1_position(res1)
    );
    dam_host u_host (
        .core_clk(core_clk), .acc_ack(acc_ack), .acc_wr_done(acc_wr_done),
        .acc_wr_refused(acc_wr_refused), .acc_rdata(acc_rdata), .acc_req(acc_req),
        .acc_wr(acc_wr), .acc_dev(acc_dev), .acc_off(acc_off), .acc_wdata(acc_wdata)
    );
    task automatic chk1(input string n, input logic e, g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %b got %b", n, e, g);
        end
    endtask : chk1
    task automatic chk8(input string n, input logic [7:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask : chk8
    task automatic wr(input logic [7:0] d, o, v, input logic ok);
        u_host.xfer(d, 1'b1, o, v, a, dn, rf, rb);
        chk1("ack", 1'b1, a);
        chk1("done", ok, dn);
        chk1("refused", ~ok, rf);
    endtask : wr
    task automatic rd(input logic [7:0] d, o, e);
        u_host.xfer(d, 1'b0, o, 8'h00, a, dn, rf, rb);
        chk1("ack", 1'b1, a);
        chk8("rdata", e, rb);
    endtask : rd
    task automatic no_ack(input logic [7:0] d);
        u_host.xfer(d, 1'b0, 8'h10, 8'h00, a, dn, rf, rb);
        chk1("ack", 1'b0, a);
    endtask : no_ack
    // index settles one cycle, positions one more; three leaves margin
    task automatic settle(input logic [15:0] t, input logic [7:0] e0);
        @(posedge core_clk);
        temp_word <= t;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk8("res0", e0, res0);
    endtask : settle
    task automatic bufs(input logic ia, ib);
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            {alarm, in_a, in_b} <= 3'(i);
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            chk1("buf_a", alarm | (ia ^ in_a), oea);
            chk1("buf_b", ib ^ in_b, oeb);
        end
    endtask : bufs
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask : tend
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        $display("mismatch watchdog exp finish got hang");
        conclude();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        rd(8'hA2, 8'h89, 8'h00);
        rd(8'hA2, 8'h8C, 8'hA2);
        rd(8'hA2, 8'h7F, 8'h01);
        tend("defaults");
        wr(8'hA2, 8'h80, 8'h00, 1'b1);
        wr(8'hA2, 8'h82, 8'hC8, 1'b1);
        wr(8'hA2, 8'h83, 8'hA5, 1'b1);
        repeat (2) @(negedge core_clk);
        chk8("res0", 8'hC8, res0);
        chk8("res1", 8'hA5, res1);
        tend("manual");
        for (int i = 0; i < 10; i++) rd(8'hA2, 8'(8'h60 + i), 8'(res_all >> (72 - 8 * i)));
        wr(8'hA2, 8'h60, 8'h00, 1'b0);
        wr(8'hA2, 8'h8A, 8'h01, 1'b0);
        tend("results");
        @(posedge core_clk);
        wp <= 1'b1;
        wr(8'hA2, 8'h89, 8'h04, 1'b1);
        wr(8'hA2, 8'h82, 8'h99, 1'b0);
        wr(8'hA2, 8'h70, 8'h3C, 1'b1);
        rd(8'hA2, 8'h70, 8'h3C);
        @(posedge core_clk);
        wp <= 1'b0;
        wr(8'hA2, 8'h82, 8'h5A, 1'b1);
        // position register follows the manual byte one cycle later
        @(negedge core_clk);
        chk8("res0", 8'h5A, res0);
        wr(8'hA2, 8'h89, 8'h00, 1'b1);
        tend("protect");
        wr(8'hA0, 8'h10, 8'h77, 1'b1);
        rd(8'hA0, 8'h10, 8'h77);
        wr(8'hA0, 8'h89, 8'h0C, 1'b1);
        rd(8'hA2, 8'h89, 8'h00);
        wr(8'hA0, 8'h82, 8'h11, 1'b1);
        rd(8'hA2, 8'h82, 8'h5A);
        wr(8'hA2, 8'h89, 8'h08, 1'b1);
        wr(8'hA0, 8'h10, 8'h55, 1'b0);
        rd(8'hA0, 8'h10, 8'h77);
        tend("aux");
        wr(8'hA2, 8'h89, 8'h28, 1'b1);
        no_ack(8'hA0);
        wr(8'hA2, 8'h7F, 8'h00, 1'b1);
        wr(8'hA2, 8'h90, 8'h66, 1'b0);
        rd(8'hA2, 8'h90, 8'h77);
        wr(8'hA2, 8'h7F, 8'h01, 1'b1);
        wr(8'hA2, 8'h89, 8'h20, 1'b1);
        wr(8'hA2, 8'h7F, 8'h00, 1'b1);
        wr(8'hA2, 8'h90, 8'h66, 1'b1);
        rd(8'hA2, 8'h90, 8'h66);
        tend("single");
        wr(8'hA2, 8'h7F, 8'h02, 1'b1);
        wr(8'hA2, 8'h80, 8'h0F, 1'b1);
        wr(8'hA2, 8'hA0, 8'h32, 1'b1);
        wr(8'hA2, 8'hA1, 8'h33, 1'b1);
        wr(8'hA2, 8'h7F, 8'h03, 1'b1);
        wr(8'hA2, 8'hA1, 8'hC3, 1'b1);
        wr(8'hA2, 8'h7F, 8'h01, 1'b1);
        wr(8'hA2, 8'h89, 8'h00, 1'b1);
        wr(8'hA2, 8'h80, 8'h01, 1'b1);
        settle(16'h1900, 8'h32);
        settle(16'h1B00, 8'h33);
        chk8("res1", 8'hC3, res1);
        settle(16'h1980, 8'h33);
        settle(16'h1880, 8'h32);
        settle(16'hC400, 8'h0F);
        tend("lookup");
        wr(8'hA2, 8'h8C, 8'hB4, 1'b1);
        wr(8'hA2, 8'h89, 8'h10, 1'b1);
        no_ack(8'hA2);
        rd(8'hB4, 8'h89, 8'h10);
        bufs(1'b0, 1'b0);
        wr(8'hB4, 8'h89, 8'h13, 1'b1);
        bufs(1'b1, 1'b1);
        tend("address and buffers");
        conclude();
    end
endmodule : tb_top

// *** rtl/dam_pkg.sv ***
// Purpose: constants for the dual address memory protect block
// Assumes: byte access port fed by a two-wire front end
// Notes:   offsets are byte offsets inside a device address space
package dam_pkg;
    localparam logic [7:0]  DEV_MAIN_FIXED  = 8'hA2;
    localparam logic [7:0]  DEV_AUX         = 8'hA0;
    localparam logic [7:0]  DEV_ADDR_RST    = 8'hA2;
    localparam logic [7:0]  OFF_TABLE_SEL   = 8'h7F;
    localparam logic [7:0]  OFF_TEMP_IDX_EN = 8'h80;
    localparam logic [7:0]  OFF_RES0_MAN    = 8'h82;
    localparam logic [7:0]  OFF_RES1_MAN    = 8'h83;
    localparam logic [7:0]  OFF_CONFIG      = 8'h89;
    localparam logic [7:0]  OFF_RSVD_LO     = 8'h8A;
    localparam logic [7:0]  OFF_RSVD_HI     = 8'h8B;
    localparam logic [7:0]  OFF_DEV_ADDR    = 8'h8C;
    localparam logic [7:0]  OFF_TABLE_BASE  = 8'h80;
    localparam logic [7:0]  OFF_SRAM_BASE   = 8'h60;
    localparam logic [7:0]  OFF_MEAS_BASE   = 8'h60;
    localparam logic [7:0]  OFF_MEAS_LAST   = 8'h69;
    localparam logic [7:0]  OFF_LUT_BASE    = 8'h80;
    // configuration byte fields
    localparam int          CFG_SINGLE_ADDR = 5;
    localparam int          CFG_ADDR_SRC    = 4;
    localparam int          CFG_AUX_LOCK    = 3;
    localparam int          CFG_MAIN_LOCK   = 2;
    localparam int          CFG_BUF_A_INV   = 1;
    localparam int          CFG_BUF_B_INV   = 0;
    localparam logic [7:0]  CFG_RST         = 8'h00;
    localparam logic [7:0]  TABLE_SEL_RST   = 8'h01;
    localparam logic        TEMP_IDX_EN_RST = 1'b1;
    localparam logic [7:0]  TBL_00          = 8'h00;
    localparam logic [7:0]  TBL_01          = 8'h01;
    localparam logic [7:0]  TBL_02          = 8'h02;
    localparam logic [7:0]  TBL_03          = 8'h03;
    // lookup index: 2 degree bands from -40 to +104, 72 bands
    localparam logic signed [8:0] LUT_T_MIN = -9'sd40;
    localparam logic [6:0]  LUT_LAST_IDX    = 7'd71;
    localparam logic [6:0]  LUT_IDX_RST     = 7'd0;
    // one degree in temperature word units (1/256 degree steps)
    localparam logic signed [16:0] HYST_1DEG = 17'sh00100;
    localparam logic [7:0]  RD_UNMAPPED     = 8'h00;
    localparam logic [7:0]  POS_RST         = 8'h00;
endpackage : dam_pkg

// *** rtl/dam_top.sv ***
// Purpose: address decode, table mapping and write protection of the
//          monitor memory, plus resistor selection and buffer outputs
// Assumes: acc_* is one byte access per request from the serial front end,
//          device address given with the read/write bit cleared
// Notes:   answers are registered and appear one cycle after the request
`timescale 1ns/1ps
module dam_top
    import dam_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        acc_req,
    input  wire logic [7:0]  acc_dev,
    input  wire logic        acc_wr,
    input  wire logic [7:0]  acc_off,
    input  wire logic [7:0]  acc_wdata,
    output logic             acc_ack,
    output logic             acc_wr_done,
    output logic             acc_wr_refused,
    output logic [7:0]       acc_rdata,
    input  wire logic [15:0] temp_word,
    input  wire logic [15:0] vcc_word,
    input  wire logic [15:0] mon1_word,
    input  wire logic [15:0] mon2_word,
    input  wire logic [15:0] mon3_word,
    input  wire logic        write_protect_pin,
    input  wire logic        monitor_alarm_summary,
    input  wire logic        buffer_a_input,
    input  wire logic        buffer_b_input,
    output logic             buffer_a_output,
    output logic             buffer_a_output_oen,
    output logic             buffer_b_output,
    output logic             buffer_b_output_oen,
    output logic [7:0]       res0_position,
    output logic [7:0]       res1_position
);

    // memory arrays; contents are nonvolatile storage, so no reset
    logic [7:0] aux_mem   [0:255];
    logic [7:0] main_low  [0:127];
    logic [7:0] tbl01_mem [0:127];
    logic [7:0] lut0_mem  [0:127];
    logic [7:0] lut1_mem  [0:127];

    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [7:0] dev_addr_q;
    logic [7:0] dev_addr_d;
    logic [7:0] tsel_q;
    logic [7:0] tsel_d;
    logic       ten_q;
    logic       ten_d;
    logic [7:0] man0_q;
    logic [7:0] man0_d;
    logic [7:0] man1_q;
    logic [7:0] man1_d;

    logic       ack_q;
    logic       ack_d;
    logic       wdone_q;
    logic       wdone_d;
    logic       wref_q;
    logic       wref_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    logic [6:0] idx_q;
    logic [6:0] idx_d;
    logic [7:0] res0_q;
    logic [7:0] res0_d;
    logic [7:0] res1_q;
    logic [7:0] res1_d;
    logic       bufa_q;
    logic       bufa_d;
    logic       bufb_q;
    logic       bufb_d;

    // write strobes toward the arrays
    logic       wr_aux;
    logic       wr_low;
    logic       wr_t01;
    logic       wr_l0;
    logic       wr_l1;

    logic [7:0] main_addr;
    logic       hit_main;
    logic       hit_aux;
    logic       single_mode;
    logic       main_locked;
    logic       aux_locked;
    logic [6:0] raw_idx;
    logic [6:0] raw_idx_hy;

    // lookup band of a temperature word, clamped to the table
    function automatic logic [6:0] band_of(input logic signed [16:0] t);
        logic signed [16:0] rel;
        logic signed [16:0] band;
        rel  = t - (17'(LUT_T_MIN) <<< 8);
        band = rel >>> 9;
        if (band < 0) begin
            band_of = 7'd0;
        end else if (band > 17'(LUT_LAST_IDX)) begin
            band_of = LUT_LAST_IDX;
        end else begin
            band_of = band[6:0];
        end
    endfunction : band_of

    // big-endian byte of a 16 bit measurement word
    function automatic logic [7:0] word_byte(input logic [15:0] w, input logic lo);
        word_byte = lo ? w[7:0] : w[15:8];
    endfunction : word_byte

    always_comb begin
        single_mode = cfg_q[CFG_SINGLE_ADDR];
        main_addr   = cfg_q[CFG_ADDR_SRC] ? dev_addr_q : DEV_MAIN_FIXED;
        hit_main    = acc_req && (acc_dev == main_addr);
        // aux address silent in single-address mode
        hit_aux     = acc_req && !single_mode && (acc_dev == DEV_AUX)
                      && (acc_dev != main_addr);
        // main lock needs pin high; pin low unlocks the main side
        main_locked = cfg_q[CFG_MAIN_LOCK] && write_protect_pin;
        aux_locked  = cfg_q[CFG_AUX_LOCK];
    end

    // temperature index with hysteresis: move up as soon as the band is
    // entered, move down only one degree below the band edge
    always_comb begin
        raw_idx    = band_of(17'(signed'(temp_word)));
        raw_idx_hy = band_of(17'(signed'(temp_word)) + HYST_1DEG);
        idx_d      = idx_q;
        if (raw_idx > idx_q) begin
            idx_d = raw_idx;
        end else if (raw_idx_hy < idx_q) begin
            idx_d = raw_idx_hy;
        end
    end

    always_comb begin
        if (ten_q) begin
            res0_d = lut0_mem[OFF_LUT_BASE[6:0] + idx_q];
            res1_d = lut1_mem[OFF_LUT_BASE[6:0] + idx_q];
        end else begin
            res0_d = man0_q;
            res1_d = man1_q;
        end
    end

    always_comb begin
        bufa_d = monitor_alarm_summary
                 | (cfg_q[CFG_BUF_A_INV] ^ buffer_a_input);
        bufb_d = cfg_q[CFG_BUF_B_INV] ^ buffer_b_input;
    end

    // access decode: reads, protected writes and register side effects
    always_comb begin
        cfg_d      = cfg_q;
        dev_addr_d = dev_addr_q;
        tsel_d     = tsel_q;
        ten_d      = ten_q;
        man0_d     = man0_q;
        man1_d     = man1_q;
        ack_d      = hit_main || hit_aux;
        wdone_d    = 1'b0;
        wref_d     = 1'b0;
        rdata_d    = RD_UNMAPPED;
        wr_aux     = 1'b0;
        wr_low     = 1'b0;
        wr_t01     = 1'b0;
        wr_l0      = 1'b0;
        wr_l1      = 1'b0;
        if (hit_aux) begin
            // aux space is its own 256 bytes, never the tables
            rdata_d = aux_mem[acc_off];
            if (acc_wr) begin
                if (aux_locked) begin
                    wref_d = 1'b1;
                end else begin
                    wr_aux  = 1'b1;
                    wdone_d = 1'b1;
                end
            end
        end else if (hit_main && !acc_off[7]) begin
            if (acc_off >= OFF_MEAS_BASE && acc_off <= OFF_MEAS_LAST) begin
                // live results; read-only, writes dropped
                unique case (acc_off[3:1])
                    3'd0:    rdata_d = word_byte(temp_word, acc_off[0]);
                    3'd1:    rdata_d = word_byte(vcc_word, acc_off[0]);
                    3'd2:    rdata_d = word_byte(mon1_word, acc_off[0]);
                    3'd3:    rdata_d = word_byte(mon2_word, acc_off[0]);
                    default: rdata_d = word_byte(mon3_word, acc_off[0]);
                endcase
                wref_d = acc_wr;
            end else if (acc_off == OFF_TABLE_SEL) begin
                rdata_d = tsel_q;
                if (acc_wr) begin
                    tsel_d  = acc_wdata;
                    wdone_d = 1'b1;
                end
            end else if (acc_off >= OFF_SRAM_BASE) begin
                // flags and reserved scratch bytes, no lock applies
                rdata_d = main_low[acc_off[6:0]];
                if (acc_wr) begin
                    wr_low  = 1'b1;
                    wdone_d = 1'b1;
                end
            end else begin
                rdata_d = main_low[acc_off[6:0]];
                if (acc_wr) begin
                    if (main_locked) begin
                        wref_d = 1'b1;
                    end else begin
                        wr_low  = 1'b1;
                        wdone_d = 1'b1;
                    end
                end
            end
        end else if (hit_main) begin
            // upper half: table chosen by the select byte
            if (tsel_q == TBL_00 && single_mode) begin
                rdata_d = aux_mem[{1'b0, acc_off[6:0]}];
                if (acc_wr) begin
                    // pin has no say over this table here
                    if (aux_locked) begin
                        wref_d = 1'b1;
                    end else begin
                        wr_aux  = 1'b1;
                        wdone_d = 1'b1;
                    end
                end
            end else if (tsel_q == TBL_01) begin
                unique case (acc_off)
                    OFF_TEMP_IDX_EN: rdata_d = {7'd0, ten_q};
                    OFF_RES0_MAN:    rdata_d = man0_q;
                    OFF_RES1_MAN:    rdata_d = man1_q;
                    OFF_CONFIG:      rdata_d = {2'b00, cfg_q[5:0]};
                    OFF_RSVD_LO:     rdata_d = RD_UNMAPPED;
                    OFF_RSVD_HI:     rdata_d = RD_UNMAPPED;
                    OFF_DEV_ADDR:    rdata_d = dev_addr_q;
                    default:         rdata_d = tbl01_mem[acc_off[6:0]];
                endcase
                if (acc_wr) begin
                    if (main_locked) begin
                        wref_d = 1'b1;
                    end else if (acc_off == OFF_RSVD_LO || acc_off == OFF_RSVD_HI) begin
                        wref_d = 1'b1;
                    end else begin
                        wdone_d = 1'b1;
                        unique case (acc_off)
                            OFF_TEMP_IDX_EN: ten_d = acc_wdata[0];
                            OFF_RES0_MAN:    man0_d = acc_wdata;
                            OFF_RES1_MAN:    man1_d = acc_wdata;
                            // lock bits live here, so only main reaches them
                            OFF_CONFIG:      cfg_d = {2'b00, acc_wdata[5:0]};
                            OFF_DEV_ADDR:    dev_addr_d = acc_wdata;
                            default:         wr_t01 = 1'b1;
                        endcase
                    end
                end
            end else if (tsel_q == TBL_02 || tsel_q == TBL_03) begin
                rdata_d = (tsel_q == TBL_02) ? lut0_mem[acc_off[6:0]]
                                             : lut1_mem[acc_off[6:0]];
                if (acc_wr) begin
                    if (main_locked) begin
                        wref_d = 1'b1;
                    end else begin
                        wr_l0   = (tsel_q == TBL_02);
                        wr_l1   = (tsel_q == TBL_03);
                        wdone_d = 1'b1;
                    end
                end
            end else begin
                // no table behind this select value
                wref_d = acc_wr;
            end
        end
    end

    // array writes; storage has no reset by nature
    always_ff @(posedge core_clk) begin
        if (wr_aux) begin
            aux_mem[hit_aux ? acc_off : {1'b0, acc_off[6:0]}] <= acc_wdata;
        end
        if (wr_low) begin
            main_low[acc_off[6:0]] <= acc_wdata;
        end
        if (wr_t01) begin
            tbl01_mem[acc_off[6:0]] <= acc_wdata;
        end
        if (wr_l0) begin
            lut0_mem[acc_off[6:0]] <= acc_wdata;
        end
        if (wr_l1) begin
            lut1_mem[acc_off[6:0]] <= acc_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q      <= CFG_RST;
            dev_addr_q <= DEV_ADDR_RST;
            tsel_q     <= TABLE_SEL_RST;
            ten_q      <= TEMP_IDX_EN_RST;
            man0_q     <= POS_RST;
            man1_q     <= POS_RST;
            ack_q      <= 1'b0;
            wdone_q    <= 1'b0;
            wref_q     <= 1'b0;
            rdata_q    <= RD_UNMAPPED;
            idx_q      <= LUT_IDX_RST;
            res0_q     <= POS_RST;
            res1_q     <= POS_RST;
            bufa_q     <= 1'b0;
            bufb_q     <= 1'b0;
        end else begin
            cfg_q      <= cfg_d;
            dev_addr_q <= dev_addr_d;
            tsel_q     <= tsel_d;
            ten_q      <= ten_d;
            man0_q     <= man0_d;
            man1_q     <= man1_d;
            ack_q      <= ack_d;
            wdone_q    <= wdone_d;
            wref_q     <= wref_d;
            rdata_q    <= rdata_d;
            idx_q      <= idx_d;
            res0_q     <= res0_d;
            res1_q     <= res1_d;
            bufa_q     <= bufa_d;
            bufb_q     <= bufb_d;
        end
    end

    always_comb begin
        acc_ack             = ack_q;
        acc_wr_done         = wdone_q;
        acc_wr_refused      = wref_q;
        acc_rdata           = rdata_q;
        res0_position       = res0_q;
        res1_position       = res1_q;
        // open drain: pin data is always low, enable low pulls the line
        buffer_a_output     = 1'b0;
        buffer_a_output_oen = bufa_q;
        buffer_b_output     = 1'b0;
        buffer_b_output_oen = bufb_q;
    end

endmodule : dam_top
